// ### asclk_codec_model.sv
// Behavioural codec at the far side: measures the clock pins and the frame length.
// Assumes pins settle within 1 ns of a source clock edge; divisor 0 is not measured.
`timescale 1ns/1ns
module asclk_codec_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic master_clock_pin,
  input wire logic serial_bit_clock_pin,
  input wire logic frame_sync,
  output logic [15:0] mck_period,
  output logic [15:0] sck_period,
  output logic [15:0] frame_bits
);
  logic [15:0] mck_cnt;
  logic [15:0] sck_cnt;
  logic [15:0] bit_cnt;
  logic mck_q;
  logic sck_q;
  logic fs_q;
  initial begin
    {mck_period, sck_period, frame_bits, mck_cnt, sck_cnt, bit_cnt} = '0;
    {mck_q, sck_q, fs_q} = 3'b000;
    forever begin
      @(posedge ref_clk);
      #1;
      if (!rst_n) begin
        {mck_cnt, sck_cnt, bit_cnt} = '0;
        {mck_q, sck_q, fs_q} = 3'b000;
      end else begin
        mck_cnt++;
        sck_cnt++;
        // Periods in source cycles, rise to rise
        if (master_clock_pin && !mck_q) begin
          mck_period = mck_cnt;
          mck_cnt = 0;
        end
        if (serial_bit_clock_pin && !sck_q) begin
          sck_period = sck_cnt;
          sck_cnt = 0;
          bit_cnt++;
        end
        if (frame_sync !== fs_q) begin
          frame_bits = bit_cnt;
          bit_cnt = 0;
        end
        mck_q = master_clock_pin;
        sck_q = serial_bit_clock_pin;
        fs_q = frame_sync;
      end
    end
  end
endmodule

// ### asclk_defines.svh
// Offsets, field positions, reset values and timing counts of the clock unit.
// Assumes byte addresses on an 8-bit register port, one 32-bit word each.
`ifndef ASCLK_DEFINES_SVH
`define ASCLK_DEFINES_SVH

`define ASCLK_OFF_MAIN 8'h00
`define ASCLK_OFF_CLKCTL 8'h04
`define ASCLK_OFF_SYNC 8'h08
`define ASCLK_OFF_FLAGS 8'h0C
`define ASCLK_OFF_MASK 8'h10

`define ASCLK_MAIN_ENABLE 0
`define ASCLK_MAIN_CKEN 1
`define ASCLK_SYNC_CKEN 1

`define ASCLK_CC_MASTER_CLOCK_OUT_ENABLE 0
`define ASCLK_CC_MASTER_CLOCK_SOURCE_SELECT 1
`define ASCLK_CC_SERIAL_CLOCK_SOURCE_SELECT 2
`define ASCLK_CC_SLOTW_LSB 3
`define ASCLK_CC_NSLOT_LSB 8
`define ASCLK_CC_SCKDIV_LSB 16
`define ASCLK_CC_SERIAL_CLOCK_DIVIDER_LSB 24

`define ASCLK_FLAG_FRAME 0
`define ASCLK_FLAG_SYNC 1
`define ASCLK_FLAG_BUSERR 2
`define ASCLK_NUM_FLAGS 3

`define ASCLK_RST_WORD 32'h0000_0000
`define ASCLK_SYNC_CYCLES 3

`endif

// ### asclk_div.sv
// Integer clock divider: period of div+1 source cycles.
// Assumes en and div come from registers on the same clock.
`timescale 1ns/1ns
module asclk_div #(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  asclk_div_if.chan d
);
  import asclk_pkg::*;

  logic [DIV_W-1:0] cnt;
  logic level;
  logic [DIV_W-1:0] next_cnt;
  logic [DIV_W-1:0] half;

  // Period of div+1 cycles; high for the first half, rounded down
  assign next_cnt = (!d.en || cnt >= d.div) ? '0 : DIV_W'(cnt + 1'b1);
  assign half = DIV_W'(({1'b0, d.div} + 1'b1) >> 1);
  assign d.tick = d.en && (cnt == '0);
  assign d.level = level;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      level <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level <= d.en && (next_cnt < half);
    end
  end

  a_div_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !d.en |=> !level) else $error("divider output high while disabled");
  a_div_tick_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (d.tick && d.div == DIV_W'(1) && $stable(d.en)) |=> (!d.tick || !d.en))
    else $error("divider tick came early");
endmodule

// ### asclk_div_if.sv
// Carrier between the clock unit top and one of its divider channels.
// Assumes both ends share the source clock.
`timescale 1ns/1ns
interface asclk_div_if #(parameter int DIV_W = 8);
  logic en;
  logic [DIV_W-1:0] div;
  logic tick;
  logic level;
  modport ctl (output en, output div, input tick, input level);
  modport chan (input en, input div, output tick, output level);
endinterface

// ### asclk_pkg.sv
// Types shared by the clock unit modules.
// Assumes the defines header is compiled alongside.
package asclk_pkg;
  typedef logic [31:0] asclk_word_t;
  typedef logic [7:0] asclk_addr_t;
  typedef enum logic [0:0] {
    ASCLK_SYNC_IDLE = 1'b0,
    ASCLK_SYNC_BUSY = 1'b1
  } asclk_sync_t;
endpackage

// ### asclk_top.sv
// Clock unit of a serial audio controller: master clock, bit clock, frame sync.
// Assumes ref_clk is the unit source clock and a same-clock register master.
`timescale 1ns/1ns
`include "asclk_defines.svh"

module asclk_top #(
  parameter int DIV_W = 8,
  parameter int SYNC_CYC = `ASCLK_SYNC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire asclk_pkg::asclk_addr_t reg_addr,
  input wire asclk_pkg::asclk_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output asclk_pkg::asclk_word_t reg_rdata,
  output logic master_clock_pin,
  output logic serial_bit_clock_pin,
  output logic frame_sync,
  output logic bus_error,
  output logic irq
);
  import asclk_pkg::*;

  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
    $error("DIV_W must lie in 1..8");
  end
  if (SYNC_CYC < 1 || SYNC_CYC > 15) begin : g_bad_sync
    $error("SYNC_CYC must lie in 1..15");
  end

  function automatic logic hit(input asclk_addr_t a, input asclk_addr_t off);
    hit = (a == off);
  endfunction

  // Last bit index of a slot: eight times code+1, minus one
  function automatic logic [4:0] slot_last(input logic [1:0] code);
    slot_last = {code, 3'b111};
  endfunction

  asclk_div_if #(.DIV_W(DIV_W)) mck_if ();
  asclk_div_if #(.DIV_W(DIV_W)) sck_if ();

  // Register state
  logic main_enable;
  logic cken_req;
  logic cken_eff;
  asclk_word_t clock_unit_control;
  logic [`ASCLK_NUM_FLAGS-1:0] interrupt_flags;
  logic [`ASCLK_NUM_FLAGS-1:0] interrupt_mask;
  asclk_sync_t sync_state;
  logic [3:0] sync_cnt;

  // Framing state
  logic [4:0] bit_cnt;
  logic [2:0] slot_cnt;
  logic mck_on;
  logic sck_on;

  // Decode
  logic wr_main;
  logic wr_clkctl;
  logic wr_flags;
  logic wr_mask;
  logic mapped;
  logic sync_busy;
  logic main_ok;
  logic bus_err_evt;
  logic sync_done_evt;
  logic frame_evt;
  asclk_word_t rd_word;
  logic [`ASCLK_NUM_FLAGS-1:0] flag_set;
  logic [`ASCLK_NUM_FLAGS-1:0] flag_clr;
  logic [`ASCLK_NUM_FLAGS-1:0] next_flags;
  logic [`ASCLK_NUM_FLAGS-1:0] next_mask;

  // Fields of the clock unit control word
  logic master_clock_out_enable;
  logic master_clock_source_select;
  logic serial_clock_source_select;
  logic [1:0] slot_width_code;
  logic [2:0] slots_per_frame_field;
  logic [DIV_W-1:0] serial_clock_divider;
  logic [DIV_W-1:0] master_clock_out_divider;

  assign master_clock_out_enable = clock_unit_control[`ASCLK_CC_MASTER_CLOCK_OUT_ENABLE];
  assign master_clock_source_select = clock_unit_control[`ASCLK_CC_MASTER_CLOCK_SOURCE_SELECT];
  assign serial_clock_source_select = clock_unit_control[`ASCLK_CC_SERIAL_CLOCK_SOURCE_SELECT];
  assign slot_width_code = clock_unit_control[`ASCLK_CC_SLOTW_LSB +: 2];
  assign slots_per_frame_field = clock_unit_control[`ASCLK_CC_NSLOT_LSB +: 3];
  assign serial_clock_divider = clock_unit_control[`ASCLK_CC_SCKDIV_LSB +: DIV_W];
  assign master_clock_out_divider = clock_unit_control[`ASCLK_CC_SERIAL_CLOCK_DIVIDER_LSB +: DIV_W];

  assign wr_main = reg_wr && hit(reg_addr, `ASCLK_OFF_MAIN);
  assign wr_clkctl = reg_wr && hit(reg_addr, `ASCLK_OFF_CLKCTL);
  assign wr_flags = reg_wr && hit(reg_addr, `ASCLK_OFF_FLAGS);
  assign wr_mask = reg_wr && hit(reg_addr, `ASCLK_OFF_MASK);
  assign mapped = hit(reg_addr, `ASCLK_OFF_MAIN) || hit(reg_addr, `ASCLK_OFF_CLKCTL)
    || hit(reg_addr, `ASCLK_OFF_SYNC) || hit(reg_addr, `ASCLK_OFF_FLAGS)
    || hit(reg_addr, `ASCLK_OFF_MASK);

  assign sync_busy = (sync_state == ASCLK_SYNC_BUSY);
  assign main_ok = wr_main && !sync_busy;
  assign bus_err_evt = wr_main && sync_busy;
  assign sync_done_evt = sync_busy && (sync_cnt == 4'h1);

  // Pin channels only run with the unit and its clock enabled
  // Enables and divisors to both channels
  assign mck_if.en = mck_on;
  assign mck_if.div = master_clock_out_divider;
  assign sck_if.en = sck_on;
  assign sck_if.div = serial_clock_divider;

  asclk_div #(.DIV_W(DIV_W)) u_mck_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(mck_if.chan)
  );

  asclk_div #(.DIV_W(DIV_W)) u_sck_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(sck_if.chan)
  );

  // Master pin gated by its enable
  // Divisor zero passes the source clock; only here a pin is not a flop
  assign master_clock_pin = (master_clock_out_divider == '0) ? (mck_on & ref_clk)
    : mck_if.level;
  assign serial_bit_clock_pin = (serial_clock_divider == '0) ? (sck_on & ref_clk)
    : sck_if.level;

  // Read multiplexer; unmapped addresses read zero
  assign rd_word = hit(reg_addr, `ASCLK_OFF_MAIN) ? {30'h0, cken_req, main_enable}
    : hit(reg_addr, `ASCLK_OFF_CLKCTL) ? clock_unit_control
    : hit(reg_addr, `ASCLK_OFF_SYNC) ? {30'h0, sync_busy, 1'b0}
    : hit(reg_addr, `ASCLK_OFF_FLAGS) ? {29'h0, interrupt_flags}
    : hit(reg_addr, `ASCLK_OFF_MASK) ? {29'h0, interrupt_mask}
    : `ASCLK_RST_WORD;

  assign flag_set = {bus_err_evt, sync_done_evt, frame_evt};
  assign flag_clr = wr_flags ? reg_wdata[`ASCLK_NUM_FLAGS-1:0] : '0;
  assign next_flags = (interrupt_flags & ~flag_clr) | flag_set;
  assign next_mask = wr_mask ? reg_wdata[`ASCLK_NUM_FLAGS-1:0] : interrupt_mask;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `ASCLK_RST_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_word : `ASCLK_RST_WORD;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_unit_control <= `ASCLK_RST_WORD;
    end else if (wr_clkctl) begin
      clock_unit_control <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_enable <= 1'b0;
      cken_req <= 1'b0;
    end else if (main_ok) begin
      main_enable <= reg_wdata[`ASCLK_MAIN_ENABLE];
      cken_req <= reg_wdata[`ASCLK_MAIN_CKEN];
    end
  end

  // Clock enable takes effect only after the count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_state <= ASCLK_SYNC_IDLE;
      sync_cnt <= 4'h0;
      cken_eff <= 1'b0;
    end else begin
      case (sync_state)
        ASCLK_SYNC_IDLE: begin
          if (main_ok) begin
            sync_state <= ASCLK_SYNC_BUSY;
            sync_cnt <= 4'(SYNC_CYC);
          end
        end
        ASCLK_SYNC_BUSY: begin
          sync_cnt <= 4'(sync_cnt - 4'h1);
          if (sync_done_evt) begin
            sync_state <= ASCLK_SYNC_IDLE;
            cken_eff <= cken_req;
          end
        end
        default: begin
          sync_state <= ASCLK_SYNC_IDLE;
          sync_cnt <= 4'h0;
        end
      endcase
    end
  end

  // Masked flags ORed onto one line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_flags <= '0;
      interrupt_mask <= '0;
      irq <= 1'b0;
      bus_error <= 1'b0;
    end else begin
      interrupt_flags <= next_flags;
      interrupt_mask <= next_mask;
      irq <= |(next_flags & next_mask);
      bus_error <= bus_err_evt;
    end
  end

  // Channel enables registered so the pins start clean
  // Other clock sources are absent in this build: a set master select stops both pins, a set serial select only the bit clock pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mck_on <= 1'b0;
      sck_on <= 1'b0;
    end else begin
      mck_on <= cken_eff && main_enable && master_clock_out_enable
        && !master_clock_source_select;
      sck_on <= cken_eff && main_enable && !master_clock_source_select
        && !serial_clock_source_select;
    end
  end

  logic bit_last;
  logic slot_last_hit;
  logic [4:0] next_bit;
  logic [2:0] next_slot;

  assign bit_last = (bit_cnt >= slot_last(slot_width_code));
  assign slot_last_hit = (slot_cnt >= slots_per_frame_field);
  assign next_bit = bit_last ? 5'h00 : 5'(bit_cnt + 5'h01);
  assign next_slot = !bit_last ? slot_cnt : slot_last_hit ? 3'h0 : 3'(slot_cnt + 3'h1);
  // Frame starts at bit zero of slot zero
  assign frame_evt = sck_on && sck_if.tick && (bit_cnt == 5'h00) && (slot_cnt == 3'h0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 5'h00;
      slot_cnt <= 3'h0;
      frame_sync <= 1'b0;
    end else if (!sck_on) begin
      bit_cnt <= 5'h00;
      slot_cnt <= 3'h0;
      frame_sync <= 1'b0;
    end else if (sck_if.tick) begin
      bit_cnt <= next_bit;
      slot_cnt <= next_slot;
      if (frame_evt) begin
        frame_sync <= !frame_sync;
      end
    end
  end

  // Busy cycle count, kept apart from the down-counter it checks
  logic [3:0] busy_len;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= 4'h0;
    end else begin
      busy_len <= sync_busy ? 4'(busy_len + 4'h1) : 4'h0;
    end
  end

  a_busy_after_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    main_ok |=> sync_busy) else $error("busy not set after control write");
  a_busy_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(sync_busy) |-> busy_len == 4'(SYNC_CYC))
    else $error("busy length wrong");
  a_bus_error_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_main && sync_busy) |=> bus_error && interrupt_flags[`ASCLK_FLAG_BUSERR]
    && $stable(cken_req)) else $error("busy write not refused");
  a_no_stray_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wr_main && sync_busy) |=> !bus_error) else $error("bus error without busy write");
  // Line equals OR of masked flags
  a_irq_or_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == |(interrupt_flags & interrupt_mask)) else $error("irq mismatch");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (interrupt_flags[`ASCLK_FLAG_FRAME] && !(wr_flags && reg_wdata[`ASCLK_FLAG_FRAME]))
    |=> interrupt_flags[`ASCLK_FLAG_FRAME]) else $error("flag dropped");
  a_set_wins_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (frame_evt && wr_flags) |=> interrupt_flags[`ASCLK_FLAG_FRAME])
    else $error("event lost on clear");
  a_fs_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_evt |=> frame_sync != $past(frame_sync)) else $error("frame sync stuck");
  a_fs_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sck_on |=> !frame_sync) else $error("frame sync high while stopped");
  a_fs_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sck_on && !frame_evt) |=> $stable(frame_sync) || !sck_on)
    else $error("frame sync moved mid frame");
  a_mck_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !master_clock_out_enable |=> !mck_on) else $error("master clock not gated");
  a_mck_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cken_eff && main_enable && master_clock_out_enable && !master_clock_source_select)
    |=> mck_on) else $error("master clock not started");
  // Read data zero between reads
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == `ASCLK_RST_WORD) else $error("read data outside read slot");
  a_rdata_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && !mapped) |=> reg_rdata == `ASCLK_RST_WORD)
    else $error("unmapped read nonzero");
endmodule

// ### test_audio_serial_clock_unit.sv
// Self-checking bench for the clock unit: register port tasks and clock measurements.
// Assumes the codec model beside the design and a 50 MHz source clock.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module test_audio_serial_clock_unit;
  import asclk_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  asclk_addr_t reg_addr = 8'h00;
  asclk_word_t reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  asclk_word_t reg_rdata;
  logic master_clock_pin;
  logic serial_bit_clock_pin;
  logic frame_sync;
  logic bus_error;
  logic irq;
  logic [15:0] mck_period;
  logic [15:0] sck_period;
  logic [15:0] frame_bits;
  int n_mismatch = 0;
  int checks_done = 0;
  asclk_word_t rd;
  logic seen;
  always #10 ref_clk = ~ref_clk;
  // Longer busy window so a read and a second control write both fit inside it
  asclk_top #(.DIV_W(8), .SYNC_CYC(6)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .master_clock_pin(master_clock_pin),
    .serial_bit_clock_pin(serial_bit_clock_pin), .frame_sync(frame_sync),
    .bus_error(bus_error), .irq(irq));
  asclk_codec_model i_codec (.ref_clk(ref_clk), .rst_n(rst_n),
    .master_clock_pin(master_clock_pin), .serial_bit_clock_pin(serial_bit_clock_pin),
    .frame_sync(frame_sync), .mck_period(mck_period), .sck_period(sck_period),
    .frame_bits(frame_bits));
  task automatic wr(input asclk_addr_t a, input asclk_word_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdw(input asclk_addr_t a, output asclk_word_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic asclk_word_t cc(input logic en, input logic [1:0] w,
      input logic [2:0] n, input logic [7:0] sd, input logic [7:0] md);
    return {md, sd, 5'h00, n, 3'h0, w, 2'b00, en};
  endfunction
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #(20 * 30000);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 8'h14; a += 4) begin
      rdw(a[7:0], rd);
      `CHK("reset word", 32'h0000_0000, rd)
    end
    wr(8'h14, 32'hFFFF_FFFF);
    rdw(8'h14, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    wr(`ASCLK_OFF_CLKCTL, cc(1'b1, 2'd1, 3'd1, 8'h03, 8'h01));
    rdw(`ASCLK_OFF_CLKCTL, rd);
    `CHK("clock ctl", cc(1'b1, 2'd1, 3'd1, 8'h03, 8'h01), rd)
    wr(`ASCLK_OFF_MAIN, 32'h0000_0003);
    rdw(`ASCLK_OFF_SYNC, rd);
    `CHK("sync busy", 32'h0000_0002, rd)
    wr(`ASCLK_OFF_MAIN, 32'h0000_0003);
    #1;
    `CHK("bus error", 1'b1, bus_error)
    repeat (400) @(posedge ref_clk);
    rdw(`ASCLK_OFF_SYNC, rd);
    `CHK("sync idle", 32'h0000_0000, rd)
    rdw(`ASCLK_OFF_FLAGS, rd);
    `CHK("flags", 32'h0000_0007, rd)
    `CHK("irq masked", 1'b0, irq)
    `CHK("mck period", 16'd2, mck_period)
    `CHK("sck period", 16'd4, sck_period)
    `CHK("frame bits", 16'd32, frame_bits)
    wr(`ASCLK_OFF_MASK, 32'h0000_0002);
    #1;
    `CHK("irq on", 1'b1, irq)
    wr(`ASCLK_OFF_FLAGS, 32'h0000_0002);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    wr(`ASCLK_OFF_MASK, 32'h0000_0001);
    repeat (200) @(posedge ref_clk);
    #1;
    `CHK("irq frame", 1'b1, irq)
    wr(`ASCLK_OFF_MASK, 32'h0000_0000);
    #1;
    `CHK("irq unmasked", 1'b0, irq)
    // Every slot width code, slot counts 2, 4, 6 and 8
    for (int w = 0; w < 4; w++) begin
      wr(`ASCLK_OFF_CLKCTL, cc(1'b1, w[1:0], 3'(2 * w + 1), 8'h01, 8'(w + 2)));
      repeat (1600) @(posedge ref_clk);
      `CHK("frame bits", 16'(8 * (w + 1) * (2 * w + 2)), frame_bits)
      `CHK("mck period", 16'(w + 3), mck_period)
      `CHK("sck period", 16'd2, sck_period)
    end
    wr(`ASCLK_OFF_CLKCTL, cc(1'b0, 2'd0, 3'd0, 8'h00, 8'h00));
    repeat (4) @(posedge ref_clk);
    seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #5;
      seen = seen | master_clock_pin;
      `CHK("sck high", 1'b1, serial_bit_clock_pin)
      @(negedge ref_clk);
      #5;
      `CHK("sck low", 1'b0, serial_bit_clock_pin)
    end
    `CHK("mck off", 1'b0, seen)
    // Back-to-back flag clears across an 8-cycle frame hit a frame start
    @(posedge ref_clk);
    reg_addr <= `ASCLK_OFF_FLAGS;
    reg_wdata <= 32'h0000_0001;
    reg_wr <= 1'b1;
    repeat (8) @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Serial source select set: bit clock stops, master clock keeps running
    wr(`ASCLK_OFF_CLKCTL, cc(1'b1, 2'd0, 3'd0, 8'h01, 8'h01) | 32'h0000_0004);
    repeat (4) @(posedge ref_clk);
    seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #5;
      seen = seen | serial_bit_clock_pin;
    end
    `CHK("sck stopped", 1'b0, seen)
    `CHK("fs cleared", 1'b0, frame_sync)
    `CHK("mck period", 16'd2, mck_period)
    final_report();
  end
endmodule
